// [kwdt_consts.svh]
// Constants for the keyed watchdog timer: addresses, field positions,
// key bytes and reset values.
// Assumes a core-side special function register bus with 8-bit addresses.
`ifndef KWDT_CONSTS_SVH
`define KWDT_CONSTS_SVH

// =====================================================================
// Register addresses
`define KWDT_KEY_ADDR      8'hA6
`define KWDT_CTRL_ADDR     8'hA7

// =====================================================================
// Control/status field positions
`define KWDT_RUN_BIT       0
`define KWDT_OVF_BIT       1
`define KWDT_SOFT_RESET_FLAG_BIT     2
`define KWDT_IDLE_BIT      4
`define KWDT_PS_LSB        5
`define KWDT_PS_MSB        7

// =====================================================================
// Key bytes
`define KWDT_KEY_SVC_1     8'h1E
`define KWDT_KEY_SVC_2     8'hE1
`define KWDT_KEY_RST_1     8'h5A
`define KWDT_KEY_RST_2     8'hA5

// =====================================================================
// Reset values and timing
`define KWDT_PS_RESET      3'h0
`define KWDT_RDATA_RESET   8'h00
`define KWDT_TIMEOUT_LOG2  14

`endif

// [kwdt_pkg.sv]
// Types for the keyed watchdog timer.
// Assumes nothing beyond a SystemVerilog compiler.
package kwdt_pkg;

  // ===================================================================
  // Key sequence tracker states
  typedef enum logic [1:0] {
    KeyIdle,
    KeyGotSvc,
    KeyGotRst
  } kwdt_key_state_e;

endpackage

// [kwdt_watchdog.sv]
// Keyed watchdog timer: key register, control/status register, counter.
// Assumes a single-cycle special function register bus driven by the core
// on clk_sys, and a reset generator that asserts sysResetIn for any reset
// source while resetn is the power-on reset.
`timescale 1ns/1ps
`include "kwdt_consts.svh"

module kwdt_watchdog #(
  parameter int TIMEOUT_LOG2 = `KWDT_TIMEOUT_LOG2
) (
  // Clock and power-on reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Any system reset source, synchronous, active high
  input  wire logic       sysResetIn,
  // Core status
  input  wire logic       cpuIdle,
  // Register bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // Reset request to the reset generator
  output logic            wdtResetReq,
  // Counter state for observation
  output logic            wdtRunning
);

  // ===================================================================
  // Local sizes
  localparam int CNT_W = TIMEOUT_LOG2 + 7;

  // ===================================================================
  // State
  kwdt_pkg::kwdt_key_state_e keyState_q;
  kwdt_pkg::kwdt_key_state_e keyState_d;
  logic [CNT_W-1:0]          count_q;
  logic [CNT_W-1:0]          count_d;
  logic                      run_q;
  logic                      run_d;
  logic                      ovf_q;
  logic                      ovf_d;
  logic                      soft_reset_flag_q;
  logic                      soft_reset_flag_d;
  logic                      idleFreeze_q;
  logic                      idleFreeze_d;
  logic [2:0]                prescale_q;
  logic [2:0]                prescale_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      rstReq_q;
  logic                      rstReq_d;

  // ===================================================================
  // Decoded strobes
  logic             keyWrite;
  logic             ctrlWrite;
  logic             ctrlRead;
  logic [CNT_W-1:0] limit;
  logic             atLimit;
  logic             countEnable;
  logic             svcDone;
  logic             rstDone;
  logic             badKey;
  logic [7:0]       ctrlImage;

  // Address decode of the two registers
  assign keyWrite  = sfrWrite && (sfrAddr == `KWDT_KEY_ADDR);
  assign ctrlWrite = sfrWrite && (sfrAddr == `KWDT_CTRL_ADDR);
  assign ctrlRead  = sfrRead && (sfrAddr == `KWDT_CTRL_ADDR);

  // Time-out limit doubles with each prescale code
  assign limit   = ~({CNT_W{1'b1}} << (TIMEOUT_LOG2 + int'(prescale_q)));
  assign atLimit = (count_q == limit);

  // Counting stops while the core idles only if freezing is asked for
  assign countEnable = run_q && !(idleFreeze_q && cpuIdle);

  // Control/status image; bit 3 reads as zero
  always_comb
  begin
    ctrlImage                                 = 8'h00;
    ctrlImage[`KWDT_RUN_BIT]                  = run_q;
    ctrlImage[`KWDT_OVF_BIT]                  = ovf_q;
    ctrlImage[`KWDT_SOFT_RESET_FLAG_BIT]                = soft_reset_flag_q;
    ctrlImage[`KWDT_IDLE_BIT]                 = idleFreeze_q;
    ctrlImage[`KWDT_PS_MSB:`KWDT_PS_LSB]      = prescale_q;
  end

  // ===================================================================
  // Key sequence tracker
  // A pair must be two consecutive key writes; any other byte breaks it.
  always_comb
  begin
    keyState_d = keyState_q;
    svcDone    = 1'b0;
    rstDone    = 1'b0;
    badKey     = 1'b0;
    if (keyWrite)
    begin
      case (keyState_q)
        kwdt_pkg::KeyIdle:
        begin
          if (sfrWdata == `KWDT_KEY_SVC_1)
          begin
            keyState_d = kwdt_pkg::KeyGotSvc;
          end
          else if (sfrWdata == `KWDT_KEY_RST_1)
          begin
            keyState_d = kwdt_pkg::KeyGotRst;
          end
          else
          begin
            badKey = 1'b1;
          end
        end
        kwdt_pkg::KeyGotSvc:
        begin
          keyState_d = kwdt_pkg::KeyIdle;
          if (sfrWdata == `KWDT_KEY_SVC_2)
          begin
            svcDone = 1'b1;
          end
          else
          begin
            badKey = 1'b1;
          end
        end
        kwdt_pkg::KeyGotRst:
        begin
          keyState_d = kwdt_pkg::KeyIdle;
          if (sfrWdata == `KWDT_KEY_RST_2)
          begin
            rstDone = 1'b1;
          end
          else
          begin
            badKey = 1'b1;
          end
        end
        default:
        begin
          keyState_d = kwdt_pkg::KeyIdle;
        end
      endcase
    end
    if (sysResetIn)
    begin
      keyState_d = kwdt_pkg::KeyIdle;
    end
  end

  // Tracker register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      keyState_q <= kwdt_pkg::KeyIdle;
    end
    else
    begin
      keyState_q <= keyState_d;
    end
  end

  // ===================================================================
  // Counter, flags and control fields
  // A completed service pair in the overflow cycle wins over the overflow.
  always_comb
  begin
    count_d      = count_q;
    run_d        = run_q;
    ovf_d        = ovf_q;
    soft_reset_flag_d      = soft_reset_flag_q;
    idleFreeze_d = idleFreeze_q;
    prescale_d   = prescale_q;
    rstReq_d     = 1'b0;

    // Software writes: settings stored, flags cleared by writing zero
    if (ctrlWrite)
    begin
      prescale_d   = sfrWdata[`KWDT_PS_MSB:`KWDT_PS_LSB];
      idleFreeze_d = sfrWdata[`KWDT_IDLE_BIT];
      if (!sfrWdata[`KWDT_OVF_BIT])
      begin
        ovf_d = 1'b0;
      end
      if (!sfrWdata[`KWDT_SOFT_RESET_FLAG_BIT])
      begin
        soft_reset_flag_d = 1'b0;
      end
      // The run bit is not touched by this write
    end

    // Counting
    if (countEnable)
    begin
      count_d = count_q + 1'b1;
    end

    // Service pair starts or restarts the count
    if (svcDone)
    begin
      run_d   = 1'b1;
      count_d = '0;
    end
    else if (run_q && atLimit && countEnable)
    begin
      ovf_d    = 1'b1;
      rstReq_d = 1'b1;
      run_d    = 1'b0;
      count_d  = '0;
    end

    // Wrong sequence; the set wins over a clear in the same cycle
    if (badKey)
    begin
      ovf_d = 1'b1;
    end

    // Software reset pair
    if (rstDone)
    begin
      soft_reset_flag_d  = 1'b1;
      rstReq_d = 1'b1;
      run_d    = 1'b0;
      count_d  = '0;
    end

    // Any reset source stops the counter but keeps the flags
    if (sysResetIn)
    begin
      run_d    = 1'b0;
      count_d  = '0;
      rstReq_d = 1'b0;
    end
  end

  // Counter and flag registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count_q      <= '0;
      run_q        <= 1'b0;
      ovf_q        <= 1'b0;
      soft_reset_flag_q      <= 1'b0;
      idleFreeze_q <= 1'b0;
      prescale_q   <= `KWDT_PS_RESET;
      rstReq_q     <= 1'b0;
    end
    else
    begin
      count_q      <= count_d;
      run_q        <= run_d;
      ovf_q        <= ovf_d;
      soft_reset_flag_q      <= soft_reset_flag_d;
      idleFreeze_q <= idleFreeze_d;
      prescale_q   <= prescale_d;
      rstReq_q     <= rstReq_d;
    end
  end

  // ===================================================================
  // Read data
  // Only the control/status register answers; the key register and all
  // other addresses read as zero.
  always_comb
  begin
    rdata_d = `KWDT_RDATA_RESET;
    if (ctrlRead)
    begin
      rdata_d = ctrlImage;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= `KWDT_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ===================================================================
  // Outputs straight from flip-flops
  assign sfrRdata    = rdata_q;
  assign wdtResetReq = rstReq_q;
  assign wdtRunning  = run_q;

endmodule // kwdt_watchdog

// [kwdt_watchdog_assertions.sv]
// Checker for the keyed watchdog ports.
// Assumes the top ports only; bound below.
`timescale 1ns/1ps
`include "kwdt_consts.svh"
module kwdt_watchdog_assertions #(
  parameter int TIMEOUT_LOG2 = `KWDT_TIMEOUT_LOG2
) (
  // Clock, resets and core
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       sysResetIn,
  input wire logic       cpuIdle,
  // Register bus and outputs
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic       wdtResetReq,
  input wire logic       wdtRunning
);
  localparam int Tmo = 2 ** TIMEOUT_LOG2;
  logic        svcQ, svcD, rstQ, rstD;
  logic [2:0]  psQ, psD;
  logic [15:0] ageQ, ageD;
  wire         keyWr = sfrWrite && sfrAddr == `KWDT_KEY_ADDR;
  wire         wrCs  = sfrWrite && sfrAddr == `KWDT_CTRL_ADDR;
  wire         rdCs  = sfrRead && sfrAddr == `KWDT_CTRL_ADDR;
  wire         fresh = !(svcQ || rstQ);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ==================================================================
  // Key tracker, prescale copy and undisturbed run age
  always_comb
  begin
    svcD = sysResetIn ? 1'b0 : keyWr ? fresh && sfrWdata == `KWDT_KEY_SVC_1 : svcQ;
    rstD = sysResetIn ? 1'b0 : keyWr ? fresh && sfrWdata == `KWDT_KEY_RST_1 : rstQ;
    psD = wrCs ? sfrWdata[7:5] : psQ;
    ageD = (!wdtRunning || keyWr || wrCs || cpuIdle || sysResetIn) ? '0 : ageQ + 16'h0001;
  end
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      {svcQ, rstQ, psQ, ageQ} <= '0;
    else
      {svcQ, rstQ, psQ, ageQ} <= {svcD, rstD, psD, ageD};

  // ==================================================================
  // Assertions
  svc_start_a:
    assert property (keyWr && svcQ && sfrWdata == `KWDT_KEY_SVC_2 && !sysResetIn
      |=> wdtRunning) else $error("service pair left counter stopped");
  soft_rst_a:
    assert property (keyWr && rstQ && sfrWdata == `KWDT_KEY_RST_2 && !sysResetIn
      |=> wdtResetReq && !wdtRunning) else $error("reset pair gave no request");
  sys_reset_a:
    assert property (sysResetIn |=> !wdtRunning && !wdtResetReq)
      else $error("counter alive after reset");
  req_stops_a:
    assert property (wdtResetReq |-> !wdtRunning) else $error("running during request");
  bad_key_a:
    assert property (keyWr && fresh && sfrWdata != `KWDT_KEY_SVC_1 && sfrWdata
      != `KWDT_KEY_RST_1 ##1 rdCs && !wrCs |=> sfrRdata[1]) else $error("bad key no flag");
  ovf_hold_a:
    assert property (rdCs && !wrCs ##1 rdCs && !wrCs && sfrRdata[1] |=> sfrRdata[1])
      else $error("overflow flag dropped");
  run_ro_a:
    assert property (wrCs && !wdtRunning |=> !wdtRunning) else $error("run bit written");
  key_rd_zero_a:
    assert property (sfrRead && sfrAddr == `KWDT_KEY_ADDR |=> sfrRdata == 8'h00)
      else $error("key register read not zero");
  timeout_a:
    assert property (ageQ == Tmo && psQ == 3'h0 |-> wdtResetReq)
      else $error("no request at time-out");

  // Main scenarios
  cover property (wdtResetReq);
  cover property (keyWr && svcQ);
  cover property (keyWr && rstQ);
endmodule // kwdt_watchdog_assertions

bind kwdt_watchdog kwdt_watchdog_assertions #(.TIMEOUT_LOG2(TIMEOUT_LOG2)) chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .sysResetIn(sysResetIn), .cpuIdle(cpuIdle),
  .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
  .sfrRdata(sfrRdata), .wdtResetReq(wdtResetReq), .wdtRunning(wdtRunning));

// [test_keyed_watchdog_timer.sv]
// Testbench for the keyed watchdog: bus driver and read scoreboard.
// Assumes design and checker files compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module test_keyed_watchdog_timer;
  // Stimulus, observation and bookkeeping
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        sysResetIn = 1'b0;
  logic        cpuIdle = 1'b0;
  logic [7:0]  sfrAddr = 8'h00;
  logic        sfrWrite = 1'b0;
  logic        sfrRead = 1'b0;
  logic [7:0]  sfrWdata = 8'h00;
  logic [7:0]  sfrRdata, want, bad;
  logic        wdtResetReq, wdtRunning;
  logic        rdQ = 1'b0;
  logic [7:0]  expQ[$];
  logic [31:0] rnd = 32'h3193_91ab;
  int          failures = 0;
  int          cmpCount = 0;
  int          reqCnt = 0;
  int          cyc = 0;

  always #5 clk_sys = ~clk_sys;

  // Short time-out: eight cycles at prescale zero
  kwdt_watchdog #(.TIMEOUT_LOG2(3)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .sysResetIn(sysResetIn), .cpuIdle(cpuIdle),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .wdtResetReq(wdtResetReq), .wdtRunning(wdtRunning));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One bus cycle; a read notes its expected answer
  task automatic op(input logic w, r, input logic [7:0] a, d, e = 8'h00);
    @(posedge clk_sys);
    rnd = lfsr(rnd);
    sfrWrite <= w;
    sfrRead <= r;
    sfrAddr <= a;
    sfrWdata <= d;
    if (r)
      expQ.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, rnd[7:0], rnd[15:8]);
  endtask
  task automatic key(input logic [7:0] a, b);
    op(1'b1, 1'b0, 8'hA6, a);
    op(1'b1, 1'b0, 8'hA6, b);
  endtask
  task automatic rd(input logic [7:0] e);
    op(1'b0, 1'b1, 8'hA7, rnd[7:0], e);
  endtask
  task automatic wr(input logic [7:0] d);
    op(1'b1, 1'b0, 8'hA7, d);
  endtask

  task automatic complete_run();
    if (failures == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Scoreboard, request counter and hang guard
  always @(posedge clk_sys)
  begin
    rdQ <= sfrRead && resetn;
    if (rdQ)
    begin
      want = expQ.pop_front();
      `CHK("read data", want, sfrRdata)
    end
    if (wdtResetReq === 1'b1)
      reqCnt++;
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      complete_run();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h00);
    op(1'b0, 1'b1, 8'hA6, 8'h00, 8'h00);
    wr(8'h01);
    rd(8'h00);
    key(8'h1E, 8'hE1);
    idle(2);
    @(negedge clk_sys);
    `CHK("running", 1'b1, wdtRunning)
    // The first service lands in the overflow cycle and must win over it
    repeat (3)
    begin
      idle(4);
      key(8'h1E, 8'hE1);
    end
    idle(2);
    @(negedge clk_sys);
    `CHK("requests", 0, reqCnt)
    idle(12);
    @(negedge clk_sys);
    `CHK("requests", 1, reqCnt)
    `CHK("running", 1'b0, wdtRunning)
    rd(8'h02);
    rd(8'h02);
    wr(8'h02);
    rd(8'h02);
    wr(8'h00);
    rd(8'h00);
    repeat (4)
    begin
      bad = (rnd[7:0] == 8'h1E || rnd[7:0] == 8'h5A) ? 8'h00 : rnd[7:0];
      op(1'b1, 1'b0, 8'hA6, bad);
      rd(8'h02);
      wr(8'h00);
    end
    key(8'h1E, 8'h5A);
    rd(8'h02);
    wr(8'h00);
    key(8'h5A, 8'hA5);
    idle(3);
    @(negedge clk_sys);
    `CHK("requests", 2, reqCnt)
    rd(8'h04);
    wr(8'h20);
    key(8'h1E, 8'hE1);
    idle(12);
    @(negedge clk_sys);
    `CHK("requests", 2, reqCnt)
    idle(10);
    @(negedge clk_sys);
    `CHK("requests", 3, reqCnt)
    wr(8'h10);
    cpuIdle <= 1'b1;
    key(8'h1E, 8'hE1);
    idle(20);
    cpuIdle <= 1'b0;
    @(negedge clk_sys);
    `CHK("requests", 3, reqCnt)
    idle(12);
    @(negedge clk_sys);
    `CHK("requests", 4, reqCnt)
    // Freezing off: the count runs on while the core idles
    wr(8'h00);
    cpuIdle <= 1'b1;
    key(8'h1E, 8'hE1);
    idle(12);
    cpuIdle <= 1'b0;
    @(negedge clk_sys);
    `CHK("requests", 5, reqCnt)
    wr(8'h20);
    key(8'h1E, 8'hE1);
    wr(8'h20);
    rd(8'h21);
    sysResetIn <= 1'b1;
    idle(1);
    sysResetIn <= 1'b0;
    idle(2);
    @(negedge clk_sys);
    `CHK("running", 1'b0, wdtRunning)
    rd(8'h20);
    idle(3);
    complete_run();
  end
endmodule // test_keyed_watchdog_timer
